// ---- verilog/spisd_regs.vh ----
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: 32-bit avalon data, byte addresses, one register per aligned word
// Notes: narrow registers sit in the low bits, upper bits read as zero
`ifndef SPISD_REGS_VH
`define SPISD_REGS_VH

`define SPISD_ADDR_W 4
`define SPISD_OFF_STAT 4'h0
`define SPISD_OFF_DATA 4'h4
`define SPISD_OFF_CTRL 4'h8

// status register fields
`define SPISD_ST_RATE_LO 0
`define SPISD_ST_RATE_HI 1
`define SPISD_ST_FDE 2
`define SPISD_ST_TXE 3
`define SPISD_ST_MODE_FAULT_FLAG 4
`define SPISD_ST_OVR 6
`define SPISD_ST_RXF 7

// control register fields
`define SPISD_CT_EN 0
`define SPISD_CT_MASTER 1
`define SPISD_CT_TXIE 2

// reset values
`define SPISD_RST_RATE 2'h0
`define SPISD_RST_FDE 1'h0
`define SPISD_RST_TXE 1'h1
`define SPISD_RST_EN 1'h0
`define SPISD_RST_MASTER 1'h1
`define SPISD_RST_TXIE 1'h0

// rate divisors picked by the two-bit rate select
`define SPISD_DIV_SEL0 8'h02
`define SPISD_DIV_SEL1 8'h08
`define SPISD_DIV_SEL2 8'h20
`define SPISD_DIV_SEL3 8'h80

// longest wait from a data write to the empty flag rising again on an enabled idle unit
`define SPISD_TXE_MAX_CYC 2

`endif

// ---- verilog/spisd_rate_gen.v ----
// Purpose: master serial clock generator, toggles every divisor base clocks
// Assumes: base clock output is clk_in itself
// Notes: halts at the idle level whenever not running
`timescale 1ns/1ns
`include "spisd_regs.vh"
module spisd_rate_gen #(
  parameter CNT_W = 8
) (
  input wire clk_in,
  input wire srst_in,
  input wire run_in,
  input wire [1:0] rate_sel_in,
  output reg sck_out,
  output reg sck_edge_out
);
  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] div_d;
  reg [1:0] sel_q;

  // divisor lookup
  always @* begin
    case (rate_sel_in)
      2'h0: div_d = `SPISD_DIV_SEL0;
      2'h1: div_d = `SPISD_DIV_SEL1;
      2'h2: div_d = `SPISD_DIV_SEL2;
      2'h3: div_d = `SPISD_DIV_SEL3;
      default: div_d = `SPISD_DIV_SEL0;
    endcase
  end

  // half period is one divisor, full period twice it
  always @(posedge clk_in) begin
    if (srst_in) begin
      cnt_q <= {CNT_W{1'b0}};
      sck_out <= 1'b0;
      sck_edge_out <= 1'b0;
      sel_q <= 2'h0;
    end else begin
      sel_q <= rate_sel_in;
      sck_edge_out <= 1'b0;
      // a rate change mid count restarts the half period cleanly
      if (!run_in || sel_q != rate_sel_in) begin
        cnt_q <= {CNT_W{1'b0}};
        if (!run_in) begin
          sck_out <= 1'b0;
        end
      end else if (cnt_q == div_d - 1'b1) begin
        cnt_q <= {CNT_W{1'b0}};
        sck_out <= ~sck_out;
        sck_edge_out <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// ---- verilog/spisd_ss_ctl.v ----
// Purpose: slave-select pin ownership and mode fault detection
// Assumes: ss_n_in is synchronous to clk_in
// Notes: fault_set_out is a one-cycle pulse in slave mode but stays high while a master sees ss_n_in low, already gated by the enable bit
`timescale 1ns/1ns
module spisd_ss_ctl (
  input wire clk_in,
  input wire srst_in,
  input wire enable_in,
  input wire master_in,
  input wire fde_in,
  input wire busy_in,
  input wire ss_n_in,
  output reg ss_owned_out,
  output reg fault_set_out
);
  reg ss_prev_q;
  wire ss_rise;

  assign ss_rise = ss_n_in & ~ss_prev_q;

  always @(posedge clk_in) begin
    if (srst_in) begin
      ss_prev_q <= 1'b1;
      ss_owned_out <= 1'b0;
      fault_set_out <= 1'b0;
    end else begin
      ss_prev_q <= ss_n_in;
      // slave always claims the pin, master only with fault detect
      ss_owned_out <= enable_in & (~master_in | fde_in);
      // master with fde low never looks at the pin level
      fault_set_out <= enable_in & fde_in &
        ((master_in & ~ss_n_in) | (~master_in & busy_in & ss_rise));
    end
  end
endmodule

// ---- verilog/spisd_top.v ----
// Behaviour
// - idle unit loads a written byte and raises tx empty within two cycles.
// - idle unit empties buffer at once, so two bytes can be queued.
// - busy slave keeps pending byte buffered until the transfer ends.
// - tx empty reads 1 when buffer empty, 0 otherwise; reset sets it.
// - mode fault may set only while fault detect enable is 1.
// - clearing fault detect enable leaves a set mode fault alone.
// - master without fault detect releases slave select and ignores it.
// - master with fault detect claims slave select as an input.
// - enabled slave always claims slave select as an input.
// - slave with fault detect low only loses the mode fault flag.
// - rate select 00,01,10,11 picks divisor 2,8,32,128 in master mode.
// - serial clock equals base clock over twice the divisor.
// - rate select ignored in slave mode; reset clears it to 00.
// - data write loads the transmit buffer only.
// - data read returns the receive buffer.
// - separate tx and rx byte buffers, neither reset.
// - tx empty sets on each load into shifter; interrupt if enabled.
// - mode fault: slave select rising in slave transfer, or low in master.
// - status read with mode fault set, then data write, clears it.
// - any data read clears the receive full flag.
//
// Purpose: status, rate select and data buffers of the serial interface
// Assumes: shift engine outside, reports busy and completed bytes
// Notes: avalon slave answers one cycle after a request is raised
//
// Added by the designer: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`include "spisd_regs.vh"
module spisd_top #(
  parameter DATA_W = 32
) (
  input wire clk_in,
  input wire srst_in,
  input wire [`SPISD_ADDR_W-1:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [DATA_W-1:0] avs_writedata_in,
  input wire [3:0] avs_byteenable_in,
  output reg [DATA_W-1:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire shift_busy_in,
  input wire shift_done_in,
  input wire [7:0] shift_rx_data_in,
  input wire ss_n_in,
  output reg shift_load_out,
  output reg [7:0] shift_tx_data_out,
  output wire sck_out,
  output wire sck_edge_out,
  output wire ss_owned_out,
  output reg tx_irq_req_out,
  output reg enable_out,
  output reg master_out
);
  // control state
  reg [1:0] rate_sel_q;
  reg fde_q;
  reg txie_q;
  reg tx_empty_q;
  reg rx_full_q;
  reg ovr_q;
  reg mode_fault_flag_q;
  reg mode_fault_flag_armed_q;
  reg ovr_armed_q;
  reg [7:0] tx_buf_q;
  reg [7:0] rx_buf_q;

  // bus decode
  wire req;
  wire accept;
  wire wr_acc;
  wire rd_acc;
  wire hit_stat;
  wire hit_data;
  wire hit_ctrl;
  wire lane0;
  reg [DATA_W-1:0] rdata_d;
  reg [7:0] stat_d;
  reg [7:0] ctrl_d;

  // datapath events
  wire data_wr;
  wire data_rd;
  wire stat_rd;
  wire stat_wr;
  wire ctrl_wr;
  wire load_now;
  wire fault_set;
  wire rate_run;

  assign req = avs_read_in | avs_write_in;
  // request completes on the edge that samples waitrequest low
  assign accept = req & ~avs_waitrequest_out;
  assign wr_acc = accept & avs_write_in;
  assign rd_acc = accept & avs_read_in;
  assign hit_stat = avs_address_in == `SPISD_OFF_STAT;
  assign hit_data = avs_address_in == `SPISD_OFF_DATA;
  assign hit_ctrl = avs_address_in == `SPISD_OFF_CTRL;
  assign lane0 = avs_byteenable_in[0];

  assign data_wr = wr_acc & hit_data & lane0;
  assign data_rd = rd_acc & hit_data;
  assign stat_rd = rd_acc & hit_stat;
  assign stat_wr = wr_acc & hit_stat & lane0;
  assign ctrl_wr = wr_acc & hit_ctrl & lane0;

  // idle unit with a pending byte moves it straight into the shifter
  assign load_now = enable_out & ~tx_empty_q & ~shift_busy_in;

  // rate generator runs only as an enabled master
  assign rate_run = enable_out & master_out & shift_busy_in;

  // status word, bit 5 unused and reads zero
  always @* begin
    stat_d = 8'h00;
    stat_d[`SPISD_ST_RATE_HI:`SPISD_ST_RATE_LO] = rate_sel_q;
    stat_d[`SPISD_ST_FDE] = fde_q;
    stat_d[`SPISD_ST_TXE] = tx_empty_q;
    stat_d[`SPISD_ST_MODE_FAULT_FLAG] = mode_fault_flag_q;
    stat_d[`SPISD_ST_OVR] = ovr_q;
    stat_d[`SPISD_ST_RXF] = rx_full_q;
  end

  // control word
  always @* begin
    ctrl_d = 8'h00;
    ctrl_d[`SPISD_CT_EN] = enable_out;
    ctrl_d[`SPISD_CT_MASTER] = master_out;
    ctrl_d[`SPISD_CT_TXIE] = txie_q;
  end

  // read mux, unmapped words read zero
  always @* begin
    rdata_d = {DATA_W{1'b0}};
    if (hit_stat) begin
      rdata_d[7:0] = stat_d;
    end else if (hit_data) begin
      rdata_d[7:0] = rx_buf_q;
    end else if (hit_ctrl) begin
      rdata_d[7:0] = ctrl_d;
    end
  end

  // avalon handshake: one wait cycle, then one cycle with data valid
  always @(posedge clk_in) begin
    if (srst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= {DATA_W{1'b0}};
    end else begin
      if (req && avs_waitrequest_out) begin
        avs_waitrequest_out <= 1'b0;
        avs_readdata_out <= avs_read_in ? rdata_d : {DATA_W{1'b0}};
      end else begin
        avs_waitrequest_out <= 1'b1;
      end
    end
  end

  // software written control bits
  always @(posedge clk_in) begin
    if (srst_in) begin
      rate_sel_q <= `SPISD_RST_RATE;
      fde_q <= `SPISD_RST_FDE;
      enable_out <= `SPISD_RST_EN;
      master_out <= `SPISD_RST_MASTER;
      txie_q <= `SPISD_RST_TXIE;
    end else begin
      if (stat_wr) begin
        rate_sel_q <= avs_writedata_in[`SPISD_ST_RATE_HI:`SPISD_ST_RATE_LO];
        fde_q <= avs_writedata_in[`SPISD_ST_FDE];
      end
      if (ctrl_wr) begin
        enable_out <= avs_writedata_in[`SPISD_CT_EN];
        master_out <= avs_writedata_in[`SPISD_CT_MASTER];
        txie_q <= avs_writedata_in[`SPISD_CT_TXIE];
      end
    end
  end

  // transmit buffer; deliberately not reset
  always @(posedge clk_in) begin
    if (data_wr) begin
      tx_buf_q <= avs_writedata_in[7:0];
    end
  end

  // byte handed to the shifter, also not reset
  always @(posedge clk_in) begin
    if (load_now) begin
      shift_tx_data_out <= tx_buf_q;
    end
  end

  // tx empty: load sets, data write clears, set wins on a clash
  always @(posedge clk_in) begin
    if (srst_in) begin
      tx_empty_q <= `SPISD_RST_TXE;
      shift_load_out <= 1'b0;
    end else begin
      shift_load_out <= load_now;
      if (load_now) begin
        tx_empty_q <= 1'b1;
      end else if (data_wr) begin
        // no lockout when still full, the newer byte replaces it
        tx_empty_q <= 1'b0;
      end
    end
  end

  // level request, not latched; software owns the enable
  always @(posedge clk_in) begin
    if (srst_in) begin
      tx_irq_req_out <= 1'b0;
    end else begin
      tx_irq_req_out <= txie_q & (tx_empty_q | load_now);
    end
  end

  // receive side; buffer deliberately not reset
  always @(posedge clk_in) begin
    if (shift_done_in && !rx_full_q) begin
      rx_buf_q <= shift_rx_data_in;
    end
  end

  // rx full; the clearing read wins over a byte completing on a full buffer
  always @(posedge clk_in) begin
    if (srst_in) begin
      rx_full_q <= 1'b0;
    end else if (shift_done_in && !rx_full_q) begin
      rx_full_q <= 1'b1;
    end else if (data_rd) begin
      rx_full_q <= 1'b0;
    end
  end

  // overflow: byte arriving on a full buffer is dropped, old one kept
  always @(posedge clk_in) begin
    if (srst_in) begin
      ovr_q <= 1'b0;
    end else if (shift_done_in && rx_full_q) begin
      ovr_q <= 1'b1;
    end else if (data_rd && ovr_armed_q) begin
      ovr_q <= 1'b0;
    end
  end

  // overflow clear needs a status read first, then a data read
  always @(posedge clk_in) begin
    if (srst_in) begin
      ovr_armed_q <= 1'b0;
    end else if (stat_rd) begin
      ovr_armed_q <= ovr_q;
    end else if (data_rd) begin
      ovr_armed_q <= 1'b0;
    end
  end

  // mode fault: fde only gates the set term, never clears the flag
  always @(posedge clk_in) begin
    if (srst_in) begin
      mode_fault_flag_q <= 1'b0;
    end else if (fault_set) begin
      mode_fault_flag_q <= 1'b1;
    end else if (data_wr && mode_fault_flag_armed_q) begin
      mode_fault_flag_q <= 1'b0;
    end
  end

  // armed by a status read that sees the flag, spent by the data write
  always @(posedge clk_in) begin
    if (srst_in) begin
      mode_fault_flag_armed_q <= 1'b0;
    end else if (stat_rd) begin
      mode_fault_flag_armed_q <= mode_fault_flag_q;
    end else if (data_wr) begin
      mode_fault_flag_armed_q <= 1'b0;
    end
  end

  spisd_ss_ctl u_ss_ctl (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .enable_in(enable_out),
    .master_in(master_out),
    .fde_in(fde_q),
    .busy_in(shift_busy_in),
    .ss_n_in(ss_n_in),
    .ss_owned_out(ss_owned_out),
    .fault_set_out(fault_set)
  );

  spisd_rate_gen #(
    .CNT_W(8)
  ) u_rate_gen (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .run_in(rate_run),
    .rate_sel_in(rate_sel_q),
    .sck_out(sck_out),
    .sck_edge_out(sck_edge_out)
  );
endmodule

// ---- test/spisd_props.sv ----
// Purpose: port-level checks of the serial status block
// Assumes: bound to spisd_top, far side raises busy the cycle after a load
// Notes: flags inside the status word are judged by the bench
`timescale 1ns/1ns
`include "spisd_regs.vh"
module spisd_chk (
  input wire clk_in,
  input wire srst_in,
  input wire [`SPISD_ADDR_W-1:0] avs_address_in,
  input wire avs_write_in,
  input wire [3:0] avs_byteenable_in,
  input wire avs_waitrequest_out,
  input wire shift_busy_in,
  input wire shift_load_out,
  input wire sck_out,
  input wire ss_owned_out,
  input wire enable_out,
  input wire master_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);
  wire wr_data = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0] &&
    avs_address_in == `SPISD_OFF_DATA;
  property p_idle_load;
    (wr_data && enable_out && !shift_busy_in) ##1 !shift_busy_in |=> shift_load_out;
  endproperty
  a_idle_load: assert property (p_idle_load) else $error("idle write not loaded");
  property p_busy_hold;
    shift_busy_in |=> !shift_load_out;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("load while busy");
  property p_load_once;
    shift_load_out |=> !shift_load_out;
  endproperty
  a_load_once: assert property (p_load_once) else $error("double load");
  property p_ss_slave;
    (enable_out && !master_out) [*2] |-> ss_owned_out;
  endproperty
  a_ss_slave: assert property (p_ss_slave) else $error("slave select not owned");
  property p_ss_off;
    (!enable_out) [*2] |-> !ss_owned_out;
  endproperty
  a_ss_off: assert property (p_ss_off) else $error("slave select owned when off");
  property p_sck_idle;
    (!shift_busy_in) [*2] |=> !sck_out;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("clock runs while idle");
  property p_sck_slave;
    (!master_out) [*2] |=> !sck_out;
  endproperty
  a_sck_slave: assert property (p_sck_slave) else $error("clock runs in slave");
  property p_sck_half;
    $changed(sck_out) && shift_busy_in && enable_out && master_out |=> $stable(sck_out);
  endproperty
  a_sck_half: assert property (p_sck_half) else $error("half period below 2");
endmodule
bind spisd_top spisd_chk spisd_chk_i (.clk_in(clk_in), .srst_in(srst_in),
  .avs_address_in(avs_address_in), .avs_write_in(avs_write_in),
  .avs_byteenable_in(avs_byteenable_in), .avs_waitrequest_out(avs_waitrequest_out),
  .shift_busy_in(shift_busy_in), .shift_load_out(shift_load_out), .sck_out(sck_out),
  .ss_owned_out(ss_owned_out), .enable_out(enable_out), .master_out(master_out));

// ---- test/spisd_far_model.sv ----
// Purpose: far-side shifter, busy after each load, then an inverted byte back
// Assumes: len_in above zero
// Notes: rx lines churn outside done so stale data never looks valid
`timescale 1ns/1ns
module spisd_far_model (
  input wire clk_in,
  input wire srst_in,
  input wire load_in,
  input wire [7:0] tx_in,
  input wire hold_in,
  input wire [9:0] len_in,
  output wire busy_out,
  output reg done_out,
  output reg [7:0] rx_out
);
  reg busy_q;
  reg [9:0] cnt_q;
  reg [7:0] keep_q;
  assign busy_out = busy_q | hold_in;
  always @(posedge clk_in) begin
    done_out <= 1'h0;
    rx_out <= ~rx_out;
    if (srst_in) begin
      busy_q <= 1'h0;
      cnt_q <= 10'h000;
      rx_out <= 8'h00;
    end else if (load_in) begin
      busy_q <= 1'h1;
      cnt_q <= len_in;
      keep_q <= ~tx_in;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 10'h001;
      if (cnt_q == 10'h001) begin
        busy_q <= 1'h0;
        done_out <= 1'h1;
        rx_out <= keep_q;
      end
    end
  end
endmodule

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the serial status block
// Assumes: far model returns each loaded byte inverted
// Notes: data window is never read back to modify
`timescale 1ns/1ns
`include "spisd_regs.vh"
module testbench;
  reg clk_in = 1'h0;
  reg srst_in = 1'h1;
  reg [3:0] adr = 4'h0;
  reg rd = 1'h0;
  reg wr = 1'h0;
  reg [31:0] wdat = 32'h0;
  reg ss_n = 1'h1;
  reg hold = 1'h0;
  reg [9:0] len = 10'h014;
  reg [31:0] rdat;
  reg [7:0] last_tx;
  wire [31:0] rdo;
  wire [7:0] rx;
  wire [7:0] tx;
  wire wreq, busy, done, load, sck, sedge, owned, irq;
  integer n_fail = 0;
  integer checks_done = 0;
  integer n_load = 0;
  integer i, n, s;
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (load === 1'h1) begin
      n_load <= n_load + 1;
      last_tx <= tx;
    end
  end
  spisd_top spisd_top_i (.clk_in(clk_in), .srst_in(srst_in), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdo), .avs_waitrequest_out(wreq), .shift_busy_in(busy),
    .shift_done_in(done), .shift_rx_data_in(rx), .ss_n_in(ss_n), .shift_load_out(load),
    .shift_tx_data_out(tx), .sck_out(sck), .sck_edge_out(sedge), .ss_owned_out(owned),
    .tx_irq_req_out(irq), .enable_out(), .master_out());
  spisd_far_model spisd_far_model_i (.clk_in(clk_in), .srst_in(srst_in), .load_in(load),
    .tx_in(tx), .hold_in(hold), .len_in(len), .busy_out(busy), .done_out(done), .rx_out(rx));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [7:0] d);
    begin
      @(posedge clk_in);
      adr <= a;
      wdat <= {24'h0, d};
      wr <= w;
      rd <= !w;
      @(posedge clk_in);
      while (wreq !== 1'h0) @(posedge clk_in);
      rdat = rdo;
      wr <= 1'h0;
      rd <= 1'h0;
    end
  endtask
  task wait_load(input integer k);
    begin
      for (i = 0; i < 600 && n_load < k; i = i + 1) @(posedge clk_in);
      chk(n_load, k);
    end
  endtask
  task wait_idle;
    begin
      for (i = 0; i < 900 && busy !== 1'h0; i = i + 1) @(posedge clk_in);
      chk(busy, 1'h0);
    end
  endtask
  task t_reset;
    begin
      bus(0, `SPISD_OFF_STAT, 8'h00);
      chk(rdat, 32'h08);
      bus(1, 4'hc, 8'hff);
      bus(0, 4'hc, 8'h00);
      chk(rdat, 32'h00);
    end
  endtask
  task t_idle;
    begin
      bus(1, `SPISD_OFF_CTRL, 8'h07);
      n = n_load;
      bus(1, `SPISD_OFF_DATA, 8'ha5);
      repeat (2) @(posedge clk_in);
      #1;
      chk(n_load, n + 1);
      bus(1, `SPISD_OFF_DATA, 8'h3c);
      bus(0, `SPISD_OFF_STAT, 8'h00);
      chk({rdat[3], irq}, 32'h0);
      wait_load(n + 2);
      chk(last_tx, 8'h3c);
      chk(irq, 1'h1);
      wait_idle;
      bus(0, `SPISD_OFF_STAT, 8'h00);
      chk(rdat, 32'hc8);
      bus(0, `SPISD_OFF_DATA, 8'h00);
      chk(rdat, 32'h5a);
      bus(0, `SPISD_OFF_STAT, 8'h00);
      chk(rdat, 32'h08);
    end
  endtask
  task t_rate;
    begin
      len <= 10'h190;
      for (s = 0; s < 4; s = s + 1) begin
        bus(1, `SPISD_OFF_STAT, s[7:0]);
        bus(1, `SPISD_OFF_DATA, 8'h11);
        for (i = 0; i < 300 && sedge !== 1'h1; i = i + 1) @(posedge clk_in);
        n = 0;
        do begin
          @(posedge clk_in);
          n = n + 1;
        end while (sedge !== 1'h1 && n < 300);
        chk(n, 2 << (2 * s));
        wait_idle;
      end
      len <= 10'h014;
    end
  endtask
  task t_slave;
    begin
      bus(1, `SPISD_OFF_CTRL, 8'h01);
      hold <= 1'h1;
      n = n_load;
      bus(1, `SPISD_OFF_DATA, 8'h77);
      repeat (8) @(posedge clk_in);
      chk(n_load, n);
      chk(owned, 1'h1);
      ss_n <= 1'h0;
      @(posedge clk_in);
      ss_n <= 1'h1;
      repeat (3) @(posedge clk_in);
      bus(0, `SPISD_OFF_STAT, 8'h00);
      chk(rdat[4], 1'h0);
      hold <= 1'h0;
      wait_load(n + 1);
      chk(last_tx, 8'h77);
    end
  endtask
  task t_fault;
    begin
      wait_idle;
      bus(1, `SPISD_OFF_CTRL, 8'h03);
      bus(1, `SPISD_OFF_STAT, 8'h00);
      ss_n <= 1'h0;
      repeat (4) @(posedge clk_in);
      bus(0, `SPISD_OFF_STAT, 8'h00);
      chk({owned, rdat[4]}, 2'h0);
      bus(1, `SPISD_OFF_STAT, 8'h04);
      repeat (4) @(posedge clk_in);
      bus(0, `SPISD_OFF_STAT, 8'h00);
      chk({owned, rdat[4]}, 2'h3);
      bus(1, `SPISD_OFF_STAT, 8'h00);
      ss_n <= 1'h1;
      bus(0, `SPISD_OFF_STAT, 8'h00);
      chk(rdat[4], 1'h1);
      bus(1, `SPISD_OFF_DATA, 8'h00);
      bus(0, `SPISD_OFF_STAT, 8'h00);
      chk(rdat[4], 1'h0);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    srst_in <= 1'h0;
    t_reset;
    t_idle;
    t_rate;
    t_slave;
    t_fault;
    test_done;
  end
  initial begin
    #1000000;
    n_fail = n_fail + 1;
    test_done;
  end
endmodule
